// ---- logic/adc_cfg.svh ----
/*
  Offsets, field positions, reset values and divider figures of the
  converter configuration register bank.
  Assumes it is included by its bare name before any module that uses it.
*/
// Functional notes
// - rate/clock/chain register at index 0x01, resets to 0x96.
// - test-signal register at index 0x02, resets to 0xC0.
// - reference/bias register at index 0x03, resets to 0x60.
// - bit 6 picks daisy-chain (0) or multiple readback (1); resets 0.
// - bit 5 drives oscillator out only while clock source pin is high.
// - rate_div sets output rate: modulator (clock/2) over 64..4096; 111 never written.
// - test_src_internal 1 generates test signal inside, 0 expects outside one.
// - test_amp_sel picks single (0) or double (1) test amplitude.
// - test_freq_sel: clock/2^21, clock/2^20, 11 dc; 10 never used.
// - refbuf_on 0 powers reference buffer down, 1 enables; resets 0.
// - bias_measure_en routes bias input to channels selecting 010.
// - bias_ref_internal picks internal supply midpoint as bias reference.
// - bias_buf_on 0 powers bias buffer down, 1 enables; resets 0.
// - bias_sense_en enables bias lead-off sensing.
// - bias_lead_status read-only, resets 0, 1 means electrode disconnected.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define IDX_RATE 6'h01
`define IDX_TEST 6'h02
`define IDX_REFB 6'h03
`define IDX_IRQ_STAT 6'h04
`define IDX_IRQ_MASK 6'h05

// ==========================================================
// reset values
`define RST_RATE 8'h96
`define RST_TEST 8'hC0
`define RST_REFB 8'h60

// ==========================================================
// field positions
`define B_READBACK 6
`define B_OSC_OUT 5
`define RATE_FORBID 3'h7
`define B_TEST_SRC 4
`define B_TEST_AMP 2
`define TFREQ_SLOW 2'h0
`define TFREQ_FAST 2'h1
`define TFREQ_DC 2'h3
`define B_REFBUF 7
`define B_BIAS_MEASURE_EN 4
`define B_BIAS_REF 3
`define B_BIAS_BUF 2
`define B_BIAS_SENSE 1
`define B_BIAS_STAT 0
`define IRQ_DRDY 0
`define IRQ_LEAD 1

// ==========================================================
// dividers: code 000 is 64 modulator periods of 2 clocks = 2^7
`define RATE_LOG2_BASE 7
`define TEST_LOG2_SLOW 21

`endif

// ---- logic/adc_config_regs.sv ----
/*
  Global configuration register bank of a multichannel converter:
  rate/clock/chain, test-signal and reference/bias registers, an
  output-rate strobe, an internal test-signal generator and an
  interrupt pair (read-clear status, mask), all behind AHB-Lite.
  Assumes inputs are synchronous to i_clk and one master on the bus.
*/
`timescale 1ns/1ps
`include "adc_cfg.svh"

module adc_config_regs
  import adc_pkg::*;
#(
  parameter int RATE_LOG2_BASE = `RATE_LOG2_BASE,
  parameter int TEST_LOG2 = `TEST_LOG2_SLOW
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire ahb_req_type i_ahb,
  output ahb_rsp_type o_ahb,
  input wire logic i_clock_source_pin,
  input wire logic i_bias_lead_off,
  output logic o_readback_multi,
  output logic o_osc_out_en,
  output logic o_data_ready,
  output logic o_test_internal,
  output logic o_test_wave,
  output logic o_test_amp_x2,
  output logic o_refbuf_on,
  output logic o_bias_measure_en,
  output logic o_bias_ref_internal,
  output logic o_bias_buf_on,
  output logic o_bias_sense_en,
  output logic o_irq
);

  localparam int RCW = RATE_LOG2_BASE + 6;
  localparam int TCW = TEST_LOG2 - 1;

  initial begin
    if (RATE_LOG2_BASE < 1 || RATE_LOG2_BASE > 20) begin
      $error("RATE_LOG2_BASE out of range");
    end
    if (TEST_LOG2 < 3 || TEST_LOG2 > 30) begin
      $error("TEST_LOG2 out of range");
    end
  end

  // ==========================================================
  // bus slave
  logic [7:0] rate;
  logic [7:0] test;
  logic [7:1] refb;
  logic lead_stat;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic wr_pend;
  logic rd_pend;
  logic [5:0] idx;
  logic hi_zero;

  // reads take one wait state so the answer reflects any write just before
  wire take = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
  wire high_ok = (i_ahb.haddr[31:8] == 24'h000000);

  wire hit_rate = hi_zero && (idx == `IDX_RATE);
  wire hit_test = hi_zero && (idx == `IDX_TEST);
  wire hit_refb = hi_zero && (idx == `IDX_REFB);
  wire hit_stat = hi_zero && (idx == `IDX_IRQ_STAT);
  wire hit_mask = hi_zero && (idx == `IDX_IRQ_MASK);

  wire wr_rate = wr_pend && hit_rate;
  wire wr_test = wr_pend && hit_test;
  wire wr_refb = wr_pend && hit_refb;
  wire wr_mask = wr_pend && hit_mask;
  wire rd_stat = rd_pend && hit_stat;

  wire [7:0] refb_rd = {refb, lead_stat};
  wire [7:0] rd_byte =
    hit_rate ? rate :
    hit_test ? test :
    hit_refb ? refb_rd :
    hit_stat ? {6'h00, irq_stat} :
    hit_mask ? {6'h00, irq_mask} : 8'h00;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      idx <= 6'h00;
      hi_zero <= 1'b0;
    end else begin
      wr_pend <= take && i_ahb.hwrite;
      rd_pend <= take && !i_ahb.hwrite;
      if (take) begin
        idx <= i_ahb.haddr[7:2];
        hi_zero <= high_ok;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ahb.hrdata <= 32'h00000000;
      o_ahb.hreadyout <= 1'b1;
      o_ahb.hresp <= 1'b0;
    end else begin
      o_ahb.hresp <= 1'b0;
      if (take && !i_ahb.hwrite) begin
        o_ahb.hreadyout <= 1'b0;
      end else if (rd_pend) begin
        o_ahb.hreadyout <= 1'b1;
        o_ahb.hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ==========================================================
  // configuration registers
  wire [2:0] wr_code = i_ahb.hwdata[2:0];
  // a forbidden rate code is refused and the old divider kept
  wire [2:0] next_code = (wr_code == `RATE_FORBID) ? rate[2:0] : wr_code;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate <= `RST_RATE;
      test <= `RST_TEST;
      refb <= 7'(`RST_REFB >> 1);
    end else begin
      if (wr_rate) begin
        rate <= {i_ahb.hwdata[7:3], next_code};
      end
      if (wr_test) begin
        test <= i_ahb.hwdata[7:0];
      end
      if (wr_refb) begin
        refb <= i_ahb.hwdata[7:1];
      end
    end
  end

  assign o_readback_multi = rate[`B_READBACK];
  assign o_test_internal = test[`B_TEST_SRC];
  assign o_test_amp_x2 = test[`B_TEST_AMP];
  assign o_refbuf_on = refb[`B_REFBUF];
  assign o_bias_measure_en = refb[`B_BIAS_MEASURE_EN];
  assign o_bias_ref_internal = refb[`B_BIAS_REF];
  assign o_bias_buf_on = refb[`B_BIAS_BUF];
  assign o_bias_sense_en = refb[`B_BIAS_SENSE];

  // ==========================================================
  // oscillator out and lead status
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_osc_out_en <= 1'b0;
      lead_stat <= 1'b0;
    end else begin
      o_osc_out_en <= rate[`B_OSC_OUT] && i_clock_source_pin;
      // sensing off shows a connected electrode
      lead_stat <= refb[`B_BIAS_SENSE] && i_bias_lead_off;
    end
  end

  // ==========================================================
  // output-rate strobe: 2^(base+code) clocks per sample
  logic [RCW-1:0] rcnt;
  wire [RCW-1:0] rate_last = RCW'((64'd1 << (RATE_LOG2_BASE + int'(rate[2:0]))) - 64'd1);
  wire rate_end = (rcnt >= rate_last);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rcnt <= '0;
      o_data_ready <= 1'b0;
    end else begin
      o_data_ready <= rate_end;
      rcnt <= rate_end ? '0 : rcnt + 1'b1;
    end
  end

  // ==========================================================
  // test signal: half period 2^20 or 2^19 clocks at the default length
  logic [TCW-1:0] tcnt;
  logic wave;
  wire [1:0] tfreq = test[1:0];
  wire [TCW-1:0] test_last = (tfreq == `TFREQ_FAST) ? {1'b0, {(TCW-1){1'b1}}} : {TCW{1'b1}};
  wire pulsed = (tfreq == `TFREQ_SLOW) || (tfreq == `TFREQ_FAST);
  wire test_end = (tcnt >= test_last);
  wire next_wave = (tfreq == `TFREQ_DC) || (pulsed && wave);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tcnt <= '0;
      wave <= 1'b0;
      o_test_wave <= 1'b0;
    end else begin
      tcnt <= (test_end || !pulsed) ? '0 : tcnt + 1'b1;
      if (test_end && pulsed) begin
        wave <= !wave;
      end
      o_test_wave <= test[`B_TEST_SRC] && next_wave;
    end
  end

  // ==========================================================
  // interrupts: sticky, read-clear, a new event beats the clear
  logic lead_q;
  wire [1:0] ev = {lead_stat && !lead_q, o_data_ready};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lead_q <= 1'b0;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      lead_q <= lead_stat;
      irq_stat <= (rd_stat ? 2'h0 : irq_stat) | ev;
      if (wr_mask) begin
        irq_mask <= i_ahb.hwdata[1:0];
      end
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // checks
  logic first;
  logic [RCW:0] gap;
  logic have_prev;
  logic rate_chg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first <= 1'b1;
      gap <= '0;
      have_prev <= 1'b0;
      rate_chg <= 1'b0;
    end else begin
      first <= 1'b0;
      gap <= o_data_ready ? (RCW+1)'(1) : gap + 1'b1;
      if (o_data_ready) begin
        have_prev <= 1'b1;
      end
      rate_chg <= wr_rate ? 1'b1 : (o_data_ready ? 1'b0 : rate_chg);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_read_take;
    take && !i_ahb.hwrite;
  endsequence

  sequence s_read_answer;
    !o_ahb.hreadyout ##1 o_ahb.hreadyout;
  endsequence

  a_rate_reset_val: assert property (first |-> rate == `RST_RATE)
    else $error("rate register reset value wrong");
  a_test_reset_val: assert property (first |-> test == `RST_TEST)
    else $error("test register reset value wrong");
  a_refb_reset_val: assert property (first |-> refb_rd == `RST_REFB && !o_readback_multi)
    else $error("reference register reset value wrong");
  a_osc_out_gate: assert property (!i_clock_source_pin |=> !o_osc_out_en)
    else $error("oscillator out driven with pin low");
  a_rate_never_bad: assert property (rate[2:0] != `RATE_FORBID)
    else $error("forbidden rate code stored");
  a_drdy_period: assert property (o_data_ready && have_prev && !rate_chg |-> gap == rate_last + 1'b1)
    else $error("output rate strobe spacing wrong");
  a_test_ext_quiet: assert property (!test[`B_TEST_SRC] && !wr_test |=> !o_test_wave)
    else $error("test wave driven while external");
  a_test_dc_level: assert property (test[`B_TEST_SRC] && tfreq == `TFREQ_DC && !wr_test |=> o_test_wave)
    else $error("dc test level missing");
  a_stat_write_proof: assert property (wr_refb && !refb[`B_BIAS_SENSE] |=> !lead_stat)
    else $error("write altered lead status");
  a_sense_off_status: assert property (!o_bias_sense_en [*2] |-> !lead_stat)
    else $error("lead status set with sensing off");
  a_read_wait: assert property (s_read_take |=> s_read_answer)
    else $error("read answer timing wrong");

  // ==========================================================
  // bus, register and interrupt checks
  sequence s_write_take;
    take && i_ahb.hwrite;
  endsequence

  sequence s_lead_rise;
    lead_stat && !lead_q;
  endsequence

  // writes never stall: only reads pay the wait state
  a_write_no_wait: assert property (s_write_take |=> o_ahb.hreadyout)
    else $error("write inserted a wait state");
  a_hready_low_once: assert property (!o_ahb.hreadyout |=> o_ahb.hreadyout)
    else $error("wait state longer than one cycle");
  // no error path exists, so every answer is OKAY
  a_resp_okay: assert property (!o_ahb.hresp)
    else $error("error response issued");
  // hrdata stands until the next read completes
  a_read_data_hold: assert property (!rd_pend |=> $stable(o_ahb.hrdata))
    else $error("read data moved outside a read");
  a_upper_zero: assert property (o_ahb.hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  // a write lands whole at the data-phase edge, save a refused rate code; other cycles keep the value
  a_rate_write: assert property (wr_rate && i_ahb.hwdata[2:0] != `RATE_FORBID |=>
    rate == $past(i_ahb.hwdata[7:0]))
    else $error("rate write not stored");
  a_test_write: assert property (wr_test |=> test == $past(i_ahb.hwdata[7:0]))
    else $error("test write not stored");
  a_refb_write: assert property (wr_refb |=> refb == $past(i_ahb.hwdata[7:1]))
    else $error("reference write not stored");
  a_mask_write: assert property (wr_mask |=> irq_mask == $past(i_ahb.hwdata[1:0]))
    else $error("mask write not stored");
  a_rate_hold: assert property (!wr_rate |=> $stable(rate))
    else $error("rate register changed without a write");
  a_test_hold: assert property (!wr_test |=> $stable(test))
    else $error("test register changed without a write");
  a_refb_hold: assert property (!wr_refb |=> $stable(refb))
    else $error("reference register changed without a write");

  a_osc_out_on: assert property (rate[`B_OSC_OUT] && i_clock_source_pin |=> o_osc_out_en)
    else $error("oscillator out missing");
  a_osc_out_off: assert property (!rate[`B_OSC_OUT] |=> !o_osc_out_en)
    else $error("oscillator out driven while disabled");
  a_lead_follow: assert property (refb[`B_BIAS_SENSE] && i_bias_lead_off |=> lead_stat)
    else $error("lead status missed a disconnect");
  a_drdy_single: assert property (o_data_ready |=> !o_data_ready)
    else $error("rate strobe longer than one cycle");

  // status bits stay set until read; a new event beats the clear
  a_irq_sticky: assert property (irq_stat[`IRQ_LEAD] && !rd_stat |=> irq_stat[`IRQ_LEAD])
    else $error("lead status bit lost before read");
  a_lead_event: assert property (s_lead_rise |=> irq_stat[`IRQ_LEAD])
    else $error("lead event not recorded");
  a_stat_clear: assert property (rd_stat && !o_data_ready |=> !irq_stat[`IRQ_DRDY])
    else $error("status read did not clear");
  a_irq_on: assert property (|(irq_stat & irq_mask) |=> o_irq)
    else $error("interrupt missing");
  a_irq_off: assert property (!(|(irq_stat & irq_mask)) |=> !o_irq)
    else $error("interrupt without unmasked status");

endmodule

// ---- logic/adc_pkg.sv ----
/*
  Types of the converter configuration register bank.
  Assumes the AHB-Lite bus is 32 bits wide with a single slave.
*/
package adc_pkg;

  typedef enum logic [1:0] {
    trans_idle,
    trans_busy,
    trans_nonseq,
    trans_seq
  } htrans_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    htrans_type htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_type;

endpackage

// ---- verif/adc_global_config_regs_tb.sv ----
/*
  Self-checking bench of the configuration register bank.
  Assumes the host model drives the bus; short counts in sim.
*/
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_global_config_regs_tb;
  import adc_pkg::*;
  localparam int RB = 2;
  localparam int TL = 4;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic pin = 1'h0;
  logic lead = 1'h0;
  ahb_req_type req;
  ahb_rsp_type rsp;
  wire [8:0] ctl;
  logic dr, wave, irq;
  logic [7:0] v;
  logic [7:0] sh [1:3];
  int err_count = 0;
  int num_checks = 0;
  adc_config_regs #(.RATE_LOG2_BASE(RB), .TEST_LOG2(TL)) adc_config_regs_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ahb(req), .o_ahb(rsp),
    .i_clock_source_pin(pin), .i_bias_lead_off(lead),
    .o_readback_multi(ctl[8]), .o_osc_out_en(ctl[7]), .o_data_ready(dr),
    .o_test_internal(ctl[6]), .o_test_wave(wave), .o_test_amp_x2(ctl[5]),
    .o_refbuf_on(ctl[4]), .o_bias_measure_en(ctl[3]), .o_bias_ref_internal(ctl[2]),
    .o_bias_buf_on(ctl[1]), .o_bias_sense_en(ctl[0]), .o_irq(irq)
  );
  ahb_host_model ahb_host_model_inst (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
  initial forever #20 i_clk = ~i_clk;
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    ahb_host_model_inst.xfer(1'h1, a, d, v);
  endtask
  task automatic rd(input logic [5:0] a);
    ahb_host_model_inst.xfer(1'h0, a, 8'h00, v);
  endtask
  function automatic logic [8:0] exp_ctl(input logic p);
    exp_ctl = {sh[1][6], sh[1][5] & p, sh[2][4], sh[2][2], sh[3][7], sh[3][4:1]};
  endfunction
  function automatic int rate_clk(input int c);
    rate_clk = (2 * (64 << c)) >> (`RATE_LOG2_BASE - RB);
  endfunction
  // clocks between two strobes (w=0) or two wave edges (w=1); first gaps only resync
  task automatic gap(input logic w, output int t);
    logic p;
    repeat (3) begin
      t = 0;
      p = wave;
      do begin
        @(posedge i_clk);
        t++;
      end while (!(w ? wave !== p : dr === 1'h1) && t < 9000);
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    tally_and_finish;
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [7:0] d;
    logic [5:0] a;
    int t;
    d = 8'($urandom(32'hB51D));
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    sh = '{8'h96, 8'hC0, 8'h60};
    for (int i = 1; i < 4; i++) begin
      rd(6'(i));
      check(v, sh[i]);
    end
    check(ctl, exp_ctl(pin));
    for (int n = 0; n < 40; n++) begin
      a = 6'(1 + $urandom % 3);
      d = 8'($urandom);
      pin <= 1'($urandom);
      if (a == `IDX_RATE && d[2:0] == `RATE_FORBID) d[2:0] = 3'h6;
      if (a == `IDX_TEST && d[1:0] == 2'h2) d[1:0] = `TFREQ_DC;
      wr(a, d);
      sh[a] = ahb_host_model_inst.fix(a, d);
      sh[3][0] = 1'h0;
      rd(a);
      check(v, sh[a]);
      check(rsp.hresp, 1'h0);
      repeat (2) @(posedge i_clk);
      check(ctl, exp_ctl(pin));
    end
    for (int c = 0; c < 7; c++) begin
      wr(`IDX_RATE, 8'(c));
      gap(1'h0, t);
      check(t, rate_clk(c));
    end
    for (int c = 0; c < 2; c++) begin
      wr(`IDX_TEST, 8'(16 + c));
      gap(1'h1, t);
      check(t, (1 << (`TEST_LOG2_SLOW - 1 - c)) >> (`TEST_LOG2_SLOW - TL));
    end
    wr(`IDX_TEST, 8'h13);
    repeat (3) @(posedge i_clk);
    check(wave, 1'h1);
    wr(`IDX_TEST, 8'h03);
    repeat (3) @(posedge i_clk);
    check(wave, 1'h0);
    wr(`IDX_REFB, 8'h02);
    wr(`IDX_IRQ_MASK, 8'h02);
    rd(`IDX_IRQ_STAT);
    lead <= 1'h1;
    repeat (4) @(posedge i_clk);
    check(irq, 1'h1);
    rd(`IDX_REFB);
    check(v, 8'h63);
    wr(`IDX_REFB, 8'h02);
    rd(`IDX_REFB);
    check(v, 8'h63);
    rd(`IDX_IRQ_STAT);
    check(v[1], 1'h1);
    repeat (3) @(posedge i_clk);
    check(irq, 1'h0);
    wr(`IDX_IRQ_MASK, 8'h00);
    lead <= 1'h0;
    repeat (3) @(posedge i_clk);
    lead <= 1'h1;
    repeat (4) @(posedge i_clk);
    check(irq, 1'h0);
    lead <= 1'h0;
    repeat (3) @(posedge i_clk);
    rd(`IDX_REFB);
    check(v, 8'h62);
    rd(6'h06);
    check(v, 8'h00);
    wr(`IDX_IRQ_MASK, 8'h01);
    repeat (300) @(posedge i_clk);
    check(irq, 1'h1);
    rd(`IDX_IRQ_STAT);
    check(v[0], 1'h1);
    tally_and_finish;
  end
endmodule

// ---- verif/ahb_host_model.sv ----
/*
  Host model: single-word AHB-Lite master for the register bank.
  Assumes xfer is called just after a rising edge of i_clk.
*/
`timescale 1ns/1ps
`include "adc_cfg.svh"
module ahb_host_model
  import adc_pkg::*;
(
  input wire logic i_clk,
  input wire ahb_rsp_type i_rsp,
  output ahb_req_type o_req
);
  ahb_req_type req = '0;
  assign o_req = {req[$bits(ahb_req_type)-1:1], i_rsp.hreadyout};
  // ==========================================================
  // host side: reserved fields always go out at their fixed values
  function automatic logic [7:0] fix(input logic [5:0] a, input logic [7:0] d);
    case (a)
      `IDX_RATE: fix = {1'h1, d[6:5], 2'h2, d[2:0]};
      `IDX_TEST: fix = {3'h6, d[4], 1'h0, d[2:0]};
      `IDX_REFB: fix = {d[7], 2'h3, d[4:0]};
      default: fix = d;
    endcase
  endfunction
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
    req.hsel <= 1'h1;
    req.haddr <= {24'h0, a, 2'h0};
    req.htrans <= trans_nonseq;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge i_clk); while (i_rsp.hreadyout !== 1'h1);
    req.htrans <= trans_idle;
    req.hwdata <= {24'h0, fix(a, d)};
    do @(posedge i_clk); while (i_rsp.hreadyout !== 1'h1);
    r = i_rsp.hrdata[7:0];
  endtask
endmodule
